/* core/sound_generator.sv */
`timescale 1ns/1ps
`include "sound_defines.svh"

module sound_generator
  import sound_pkg::*;
#(
  parameter int SND_DIV = `SND_DIV_DEFAULT
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_sound,
  output logic o_irq
);

  // ***********************************************
  // Declarations
  // ***********************************************
  logic snd_tick;
  logic wave;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [1:0] mode_sel;
  logic [3:0] tempo_sel;
  logic [15:0] sound_buffer;
  logic buf_full;
  logic [15:0] sound_reg;
  logic buffer_empty_flag;
  logic output_done_flag;
  logic output_busy_flag;
  logic stop_output_bit;
  logic [1:0] irq_enable;
  logic [1:0] irq_hit;
  state_type state;
  logic [12:0] unit_cnt;
  logic [5:0] note_cnt;
  logic unit_end;
  logic note_end;
  logic load_now;
  logic finish_now;
  logic buf_wr;
  logic flags_wr;
  logic sel_wr;
  logic ctrl_wr;
  logic ien_wr;
  logic [7:0] tone_period;
  logic [7:0] tone_high;
  logic next_sound;

  // ***********************************************
  // Helpers
  // ***********************************************
  function automatic logic mode_playable(input logic [1:0] m);
    mode_playable = (m == MODE_ONESHOT) || (m == MODE_MELODY);
  endfunction

  function automatic logic word_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    word_hit = (a == off);
  endfunction

  // ***********************************************
  // Sound clock and waveform
  // ***********************************************
  sound_tick #(.SND_DIV(SND_DIV)) u_tick
  (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .o_tick(snd_tick)
  );

  // Melody keeps 50 percent duty; its length field means duration
  always_comb
  begin
    tone_period = sound_reg[`BUF_FREQ_MSB:`BUF_FREQ_LSB];
    if (mode_sel == MODE_MELODY)
      tone_high = {1'h0, tone_period[7:1]};
    else
      tone_high = {2'h0, sound_reg[`BUF_LEN_MSB:`BUF_LEN_LSB]};
  end

  tone_gen u_tone
  (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_tick(snd_tick),
    .i_run(state == ST_PLAY),
    .i_period(tone_period),
    .i_high(tone_high),
    .o_wave(wave)
  );

  // ***********************************************
  // AHB-Lite slave
  // ***********************************************
  // Zero wait states: read data is prepared in the address phase
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      wr_pend <= 1'h0;
      wr_addr <= 8'h00;
    end
    else if (i_hready)
    begin
      wr_pend <= i_hsel && i_htrans == `HTRANS_NONSEQ && i_hwrite;
      wr_addr <= i_haddr[7:0];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_hreadyout <= 1'h1;
      o_hresp <= 1'h0;
    end
    else
    begin
      o_hreadyout <= 1'h1;
      o_hresp <= 1'h0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_hrdata <= `RST_WORD;
    else if (i_hready && i_hsel && i_htrans == `HTRANS_NONSEQ && !i_hwrite)
    begin
      o_hrdata <= `RST_WORD;
      if (word_hit(i_haddr[7:0], `REG_SELECT))
      begin
        o_hrdata[`SEL_MODE_MSB:`SEL_MODE_LSB] <= mode_sel;
        o_hrdata[`SEL_TEMPO_MSB:`SEL_TEMPO_LSB] <= tempo_sel;
      end
      else if (word_hit(i_haddr[7:0], `REG_BUFFER))
        o_hrdata[15:0] <= sound_buffer;
      else if (word_hit(i_haddr[7:0], `REG_FLAGS))
      begin
        o_hrdata[`FLG_EMPTY_BIT] <= buffer_empty_flag;
        o_hrdata[`FLG_DONE_BIT] <= output_done_flag;
        o_hrdata[`FLG_BUSY_BIT] <= output_busy_flag;
      end
      else if (word_hit(i_haddr[7:0], `REG_CTRL))
        o_hrdata[`CTRL_STOP_BIT] <= stop_output_bit;
      else if (word_hit(i_haddr[7:0], `REG_IEN))
        o_hrdata[1:0] <= irq_enable;
    end
  end

  assign sel_wr = wr_pend && word_hit(wr_addr, `REG_SELECT);
  assign buf_wr = wr_pend && word_hit(wr_addr, `REG_BUFFER);
  assign flags_wr = wr_pend && word_hit(wr_addr, `REG_FLAGS);
  assign ctrl_wr = wr_pend && word_hit(wr_addr, `REG_CTRL);
  assign ien_wr = wr_pend && word_hit(wr_addr, `REG_IEN);

  // ***********************************************
  // Software registers
  // ***********************************************
  // Tempo is taken live; changing it while busy skews the unit
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      mode_sel <= MODE_NORMAL;
      tempo_sel <= 4'h0;
    end
    else if (sel_wr)
    begin
      mode_sel <= i_hwdata[`SEL_MODE_MSB:`SEL_MODE_LSB];
      tempo_sel <= i_hwdata[`SEL_TEMPO_MSB:`SEL_TEMPO_LSB];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      irq_enable <= 2'h0;
    else if (ien_wr)
      irq_enable <= i_hwdata[1:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      sound_buffer <= `RST_BUF;
    else if (buf_wr)
      sound_buffer <= i_hwdata[15:0];
  end

  // ***********************************************
  // Sequencing
  // ***********************************************
  // One unit is (tempo+1)*512 sound clocks: duration or 32nd note
  assign unit_end = snd_tick && unit_cnt == {tempo_sel, `UNIT_LOW_ONES};
  assign note_end = unit_end &&
    (mode_sel == MODE_ONESHOT ||
     note_cnt == sound_reg[`BUF_LEN_MSB:`BUF_LEN_LSB]);
  assign load_now = buf_full && mode_playable(mode_sel) && snd_tick &&
    !stop_output_bit &&
    ((state == ST_IDLE) ||
     (mode_sel == MODE_MELODY && note_end));
  assign finish_now = state == ST_PLAY && !load_now &&
    (note_end || (stop_output_bit && snd_tick));

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      state <= ST_IDLE;
    else if (load_now)
      state <= ST_PLAY;
    else if (finish_now || (state == ST_PLAY && !mode_playable(mode_sel)))
      state <= ST_IDLE;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst || load_now || state == ST_IDLE)
    begin
      unit_cnt <= 13'h0000;
      note_cnt <= 6'h00;
    end
    else if (unit_end)
    begin
      unit_cnt <= 13'h0000;
      note_cnt <= note_cnt + 6'h01;
    end
    else if (snd_tick)
      unit_cnt <= unit_cnt + 13'h0001;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      sound_reg <= `RST_BUF;
    else if (load_now)
      sound_reg <= sound_buffer;
  end

  // A write in the load cycle is newer data, so it keeps the buffer full
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      buf_full <= 1'h0;
    else if (buf_wr)
      buf_full <= 1'h1;
    else if (load_now || (stop_output_bit && snd_tick))
      buf_full <= 1'h0;
  end

  // ***********************************************
  // Flags
  // ***********************************************
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      buffer_empty_flag <= 1'h0;
    else if (buf_wr)
      buffer_empty_flag <= 1'h0;
    else if (load_now || (ctrl_wr && i_hwdata[`CTRL_STOP_BIT]))
      buffer_empty_flag <= 1'h1;
  end

  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      output_done_flag <= 1'h0;
    else if (finish_now)
      output_done_flag <= 1'h1;
    else if (buf_wr || (flags_wr && i_hwdata[`FLG_DONE_BIT]))
      output_done_flag <= 1'h0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      output_busy_flag <= 1'h0;
    else if (load_now)
      output_busy_flag <= 1'h1;
    else if (finish_now || state == ST_IDLE)
      output_busy_flag <= 1'h0;
  end

  // Stop completes on the next sound clock
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      stop_output_bit <= 1'h0;
    else if (ctrl_wr && i_hwdata[`CTRL_STOP_BIT])
      stop_output_bit <= 1'h1;
    else if (snd_tick)
      stop_output_bit <= 1'h0;
  end

  // ***********************************************
  // Interrupt and pin
  // ***********************************************
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_irq
      if (g == `IEN_EMPTY_BIT)
        assign irq_hit[g] = buffer_empty_flag && irq_enable[g];
      else
        assign irq_hit[g] = output_done_flag && irq_enable[g];
    end
  endgenerate

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_irq <= 1'h0;
    else
      o_irq <= |irq_hit;
  end

  // Short gap before an untied note gives audible articulation
  always_comb
  begin
    next_sound = wave && state == ST_PLAY;
    if (mode_sel == MODE_MELODY)
    begin
      if (sound_reg[`BUF_REST_BIT])
        next_sound = 1'h0;
      else if (!sound_reg[`BUF_TIE_BIT] && note_cnt == 6'h00 &&
               unit_cnt < `GAP_TICKS)
        next_sound = 1'h0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_sound <= 1'h0;
    else
      o_sound <= next_sound;
  end

endmodule

/* core/sound_tick.sv */
`timescale 1ns/1ps
`include "sound_defines.svh"

module sound_tick
#(
  parameter int SND_DIV = `SND_DIV_DEFAULT
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  output logic o_tick
);

  // ***********************************************
  // Sound clock as a one-cycle enable
  // ***********************************************
  // A strobe keeps one clock domain; no derived clock to route.
  logic [15:0] div_cnt;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      div_cnt <= 16'h0000;
      o_tick <= 1'h0;
    end
    else if (div_cnt == 16'(SND_DIV - 1))
    begin
      div_cnt <= 16'h0000;
      o_tick <= 1'h1;
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
      o_tick <= 1'h0;
    end
  end

endmodule

/* core/tone_gen.sv */
`timescale 1ns/1ps

module tone_gen
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_tick,
  input wire logic i_run,
  input wire logic [7:0] i_period,
  input wire logic [7:0] i_high,
  output logic o_wave
);

  // ***********************************************
  // Period and duty counter
  // ***********************************************
  logic [7:0] phase;

  always_ff @(posedge i_clk)
  begin
    if (i_srst || !i_run)
      phase <= 8'h00;
    else if (i_tick)
      phase <= (phase == i_period) ? 8'h00 : phase + 8'h01;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_wave <= 1'h0;
    else
      o_wave <= i_run && (phase <= i_high);
  end

endmodule

/* include/sound_defines.svh */
`ifndef SOUND_DEFINES_SVH
`define SOUND_DEFINES_SVH

// ***********************************************
// Clock rates
// ***********************************************
`define SYS_CLK_HZ 250000000
`define SND_CLK_HZ 32768
`define SND_DIV_DEFAULT (`SYS_CLK_HZ / `SND_CLK_HZ)

// ***********************************************
// Register byte offsets
// ***********************************************
`define REG_SELECT 8'h00
`define REG_BUFFER 8'h04
`define REG_FLAGS 8'h08
`define REG_CTRL 8'h0c
`define REG_IEN 8'h10

// ***********************************************
// Field positions
// ***********************************************
`define SEL_MODE_LSB 0
`define SEL_MODE_MSB 1
`define SEL_TEMPO_LSB 8
`define SEL_TEMPO_MSB 11
`define BUF_FREQ_LSB 0
`define BUF_FREQ_MSB 7
`define BUF_LEN_LSB 8
`define BUF_LEN_MSB 13
`define BUF_REST_BIT 14
`define BUF_TIE_BIT 15
`define FLG_EMPTY_BIT 0
`define FLG_DONE_BIT 1
`define FLG_BUSY_BIT 2
`define CTRL_STOP_BIT 8
`define IEN_EMPTY_BIT 0
`define IEN_DONE_BIT 1

// ***********************************************
// Timing and reset values
// ***********************************************
`define UNIT_LOW_ONES 9'h1ff
`define GAP_TICKS 13'h0010
`define RST_WORD 32'h0000_0000
`define RST_BUF 16'h0000
`define HTRANS_NONSEQ 2'h2

`endif

/* include/sound_pkg.sv */
package sound_pkg;

  typedef enum logic [1:0]
  {
    MODE_NORMAL = 2'h0,
    MODE_ONESHOT = 2'h1,
    MODE_MELODY = 2'h2,
    MODE_RSVD = 2'h3
  } mode_type;

  typedef enum logic
  {
    ST_IDLE = 1'h0,
    ST_PLAY = 1'h1
  } state_type;

endpackage

/* test/buzzer_listener.sv */
`timescale 1ns/1ps
// ****
// Speaker model: measures the tone
// ****
module buzzer_listener
(
  input wire logic i_clk,
  input wire logic i_sound,
  input wire logic i_clear,
  output logic [15:0] o_rises,
  output logic [15:0] o_high,
  output logic [15:0] o_period,
  output logic [15:0] o_low_max
);
  logic prev;
  logic [15:0] hcnt;
  logic [15:0] pcnt;
  logic [15:0] lcnt;
  always_ff @(posedge i_clk)
  begin
    prev <= i_sound;
    hcnt <= i_sound ? hcnt + 16'h0001 : 16'h0000;
    lcnt <= i_sound ? 16'h0000 : lcnt + 16'h0001;
    // Longest silence since clear; a note gap shows up here
    if (i_clear)
      o_low_max <= 16'h0000;
    else if (i_sound && !prev && lcnt > o_low_max)
      o_low_max <= lcnt;
    pcnt <= (i_sound && !prev) ? 16'h0001 : pcnt + 16'h0001;
    if (i_sound && !prev)
      o_period <= pcnt;
    if (!i_sound && prev)
      o_high <= hcnt;
    if (i_clear)
      o_rises <= 16'h0000;
    else if (i_sound && !prev)
      o_rises <= o_rises + 16'h0001;
  end
endmodule

/* test/sound_generator_assertions.sv */
`timescale 1ns/1ps
`include "sound_defines.svh"
// ****
// Port checks
// ****
module sound_checker
#(
  parameter int SND_DIV = `SND_DIV_DEFAULT
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_sound,
  input wire logic o_irq
);
  logic wr;
  logic [7:0] off;
  logic [1:0] mode;
  logic [1:0] ien;
  logic [15:0] hi;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // Shadow of the written fields, applied at the data phase edge
  always_ff @(posedge i_clk)
  begin
    wr <= !i_srst && i_hsel && i_hready && i_htrans == `HTRANS_NONSEQ
      && i_hwrite;
    off <= i_haddr[7:0];
    if (i_srst)
    begin
      mode <= 2'h0;
      ien <= 2'h0;
    end
    else if (wr && off == `REG_SELECT)
      mode <= i_hwdata[1:0];
    else if (wr && off == `REG_IEN)
      ien <= i_hwdata[1:0];
  end
  always_ff @(posedge i_clk)
  begin
    if (i_srst || !o_sound)
      hi <= 16'h0000;
    else
      hi <= hi + 16'h0001;
  end
  sequence rd_at(logic [7:0] a);
    i_hsel && i_hready && i_htrans == `HTRANS_NONSEQ && !i_hwrite
      && i_haddr[7:0] == a;
  endsequence
  bus_okay_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus not ready or not okay");
  reset_quiet_a: assert property ($fell(i_srst) |->
    !o_sound && !o_irq && o_hrdata == `RST_WORD)
    else $error("outputs not quiet after reset");
  irq_masked_a: assert property ((ien == 2'h0) [*2] |-> !o_irq)
    else $error("interrupt while all enables off");
  irq_cause_a: assert property ($rose(o_irq) |-> $past(ien) != 2'h0)
    else $error("interrupt rose with no enable");
  mode_quiet_a: assert property
    ((mode == 2'h0 || mode == 2'h3) [*4] |-> !o_sound)
    else $error("sound in a mode without output");
  high_bound_a: assert property (hi <= 16'(129 * SND_DIV))
    else $error("sound high too long");
  unmapped_zero_a: assert property (rd_at(8'h40) |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  mode_read_a: assert property
    (rd_at(`REG_SELECT) |=> o_hrdata[1:0] == mode)
    else $error("mode field readback wrong");
endmodule
bind sound_generator sound_checker #(.SND_DIV(SND_DIV)) checks (
  .i_clk(i_clk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
  .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_sound(o_sound),
  .o_irq(o_irq));

/* test/testbench.sv */
`timescale 1ns/1ps
`include "sound_defines.svh"
// ****
// Bench
// ****
module testbench;
  logic i_clk, i_srst, i_hsel, i_hwrite, i_clear;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  logic o_hreadyout, o_hresp, o_sound, o_irq;
  logic [15:0] rises, high, period, low;
  int err_total, n_tests, c0;
  int cycles = 0;
  sound_generator #(.SND_DIV(4)) dut (.i_clk(i_clk), .i_srst(i_srst),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_sound(o_sound), .o_irq(o_irq));
  buzzer_listener spk (.i_clk(i_clk), .i_sound(o_sound), .i_clear(i_clear),
    .o_rises(rises), .o_high(high), .o_period(period), .o_low_max(low));
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // Run ceiling well above the five scenarios
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      err_total = err_total + 1;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_haddr <= {24'h000000, a};
    i_hwrite <= w;
    i_htrans <= `HTRANS_NONSEQ;
    @(posedge i_clk);
    while (!o_hreadyout)
      @(posedge i_clk);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    @(posedge i_clk);
    while (!o_hreadyout)
      @(posedge i_clk);
    rd = o_hrdata;
  endtask
  // Polls the flags; a hang is cut by the run ceiling
  task automatic poll(input logic [31:0] mask, input logic [31:0] want);
    bus(1'b0, `REG_FLAGS, 32'h0);
    while ((rd & mask) !== want)
      bus(1'b0, `REG_FLAGS, 32'h0);
  endtask
  task automatic listen(input int n);
    i_clear <= 1'b1;
    @(posedge i_clk);
    i_clear <= 1'b0;
    repeat (n) @(posedge i_clk);
  endtask
  task automatic t_regs();
    bus(1'b0, `REG_FLAGS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h40, 32'hffffffff);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_oneshot();
    bus(1'b1, `REG_SELECT, 32'h1);
    bus(1'b1, `REG_IEN, 32'h2);
    bus(1'b1, `REG_BUFFER, 32'h0307);
    poll(32'h4, 32'h4);
    chk(rd & 32'h7, 32'h5);
    listen(300);
    chk({high, period}, {16'd16, 16'd32});
    poll(32'h4, 32'h0);
    chk(rd & 32'h7, 32'h3);
    chk(32'(rises > 16'd59 && rises < 16'd66), 32'h1);
    chk(32'(o_irq), 32'h1);
    bus(1'b1, `REG_FLAGS, 32'h2);
    bus(1'b0, `REG_FLAGS, 32'h0);
    chk(rd & 32'h7, 32'h1);
    chk(32'(o_irq), 32'h0);
    $display("test one-shot done");
  endtask
  task automatic t_melody();
    bus(1'b1, `REG_SELECT, 32'h2);
    bus(1'b1, `REG_IEN, 32'h1);
    bus(1'b1, `REG_BUFFER, 32'h000f);
    poll(32'h5, 32'h5);
    @(posedge i_clk);
    chk(32'(o_irq), 32'h1);
    bus(1'b1, `REG_BUFFER, 32'h800f);
    listen(600);
    chk({high, period}, {16'd32, 16'd64});
    // Clear after the first note's gap, then watch the tied join
    listen(1);
    poll(32'h1, 32'h1);
    repeat (200) @(posedge i_clk);
    chk(32'(low), 32'd32);
    bus(1'b1, `REG_BUFFER, 32'h410f);
    poll(32'h1, 32'h1);
    c0 = cycles;
    listen(900);
    chk(32'(rises), 32'h0);
    poll(32'h4, 32'h0);
    chk(rd & 32'h3, 32'h3);
    chk(32'(cycles - c0 > 4090 && cycles - c0 < 4102), 32'h1);
    bus(1'b1, `REG_IEN, 32'h0);
    bus(1'b0, `REG_IEN, 32'h0);
    chk(rd, 32'h0);
    chk(32'(o_irq), 32'h0);
    $display("test melody done");
  endtask
  task automatic t_tempo();
    bus(1'b1, `REG_SELECT, 32'h0101);
    bus(1'b0, `REG_SELECT, 32'h0);
    chk(rd, 32'h0101);
    bus(1'b1, `REG_BUFFER, 32'h0307);
    poll(32'h4, 32'h4);
    c0 = cycles;
    poll(32'h4, 32'h0);
    chk(32'(cycles - c0 > 4090 && cycles - c0 < 4102), 32'h1);
    $display("test tempo done");
  endtask
  task automatic t_stop();
    bus(1'b1, `REG_SELECT, 32'h1);
    bus(1'b1, `REG_BUFFER, 32'h0307);
    poll(32'h4, 32'h4);
    c0 = cycles;
    bus(1'b1, `REG_CTRL, 32'h0100);
    poll(32'h4, 32'h0);
    chk(32'(cycles - c0 < 40), 32'h1);
    chk(rd & 32'h7, 32'h3);
    bus(1'b0, `REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    listen(100);
    chk(32'(rises), 32'h0);
    bus(1'b1, `REG_SELECT, 32'h0);
    bus(1'b1, `REG_BUFFER, 32'hc507);
    bus(1'b0, `REG_FLAGS, 32'h0);
    chk(rd & 32'h7, 32'h0);
    bus(1'b0, `REG_BUFFER, 32'h0);
    chk(rd, 32'hc507);
    $display("test stop done");
  endtask
  initial
  begin
    i_srst = 1'b1;
    i_hsel = 1'b0;
    i_haddr = 32'h0;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hwdata = 32'h0;
    i_hsize = 3'h2;
    i_clear = 1'b1;
    err_total = 0;
    n_tests = 0;
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    i_clear <= 1'b0;
    t_regs();
    t_oneshot();
    t_melody();
    t_tempo();
    t_stop();
    conclude();
  end
endmodule
